// ==== shared/sscc_map.svh ====
// Register offsets, field positions and reset values of the clock control
`ifndef SSCC_MAP_SVH
`define SSCC_MAP_SVH
`define SSCC_OFF_IOM 4'h0
`define SSCC_OFF_PCC 4'h4
`define SSCC_OFF_OSC 4'h8
`define SSCC_OFF_MCM 4'hc
`define SSCC_IOM_STABLE 7
`define SSCC_IOM_HSSTOP 0
`define SSCC_IOM_LSSTOP 1
`define SSCC_PCC_SUBSTART 6
`define SSCC_PCC_CSS 4
`define SSCC_PCC_CLS 5
`define SSCC_PCC_MCS 3
`define SSCC_OSC_EXTMAIN 7
`define SSCC_OSC_SUBEXT 5
`define SSCC_OSC_SUBEN 4
`define SSCC_MCM_EXTERNAL_MAIN_SELECT 2
`define SSCC_MCM_MODE 0
`define SSCC_PCC_RST 3'h1
`define SSCC_SWITCH_NS 160
`define SSCC_CLK_NS 40
`define SSCC_SWITCH_CYC ((`SSCC_SWITCH_NS + `SSCC_CLK_NS - 1) / `SSCC_CLK_NS)
`define SSCC_STABLE_NS 400
`define SSCC_STABLE_CYC ((`SSCC_STABLE_NS + `SSCC_CLK_NS - 1) / `SSCC_CLK_NS)
`endif

// ==== shared/sscc_pkg.sv ====
// Types of the subsystem and oscillator clock control
package sscc_pkg;
   typedef enum logic [1:0] {SsccPort, SsccXtal, SsccExtIn} sscc_pin_mode_t;
   typedef enum logic [1:0] {SsccCpuHs, SsccCpuMain, SsccCpuSub} sscc_cpu_src_t;
   typedef struct packed {
      logic hsStop;
      logic lsStop;
      logic subStart;
      logic cpuSel;
      logic [2:0] cpuDiv;
      logic extMain;
      logic subExt;
      logic subEn;
      logic extSel;
      logic mainMode;
      logic [3:0] stableCnt;
      logic hsStable;
      logic [2:0] switchCnt;
      sscc_cpu_src_t cpuStat;
      logic ack;
      logic [7:0] rdData;
      logic [1:0] subPinSync1;
      logic [1:0] subPinSync2;
      logic [1:0] subPinIn;
      logic hsRun;
      logic lsRun;
      sscc_pin_mode_t pinMode;
      logic [2:0] cpuClkSel;
      logic periMain;
      logic cpuDivOk;
      logic lsStoppable;
      logic strapTaken;
   } sscc_state_t;
endpackage

// ==== core/sscc_clock_ctrl.sv ====
// Subsystem and internal oscillator clock control with Wishbone registers
// Notes on behaviour
// - High-speed stop bit halts internal oscillator
// - Two status bits report CPU clock
// - Subsystem pins are inputs unless enabled or started
// - Crystal mode by start bit or enable
// - External select plus enable gives clock input, unless the start bit forces crystal mode
// - CPU select runs undivided subsystem clock
// - Clearing subsystem enable and start bit stops subsystem clock
// - STOP mode keeps subsystem oscillation running
// - Low-speed clock never feeds the CPU
// - Low-speed oscillator runs from reset, already during reset
// - Low-speed stop bit halts and restarts
// - Unstoppable option ignores low-speed stop bit
// - Main select and mode route clocks
// - Main mode bit positions fixed
// - Internal oscillator register bit positions fixed
// - Subsystem select bits at five, four
// - Start bit six, CPU select four
`timescale 1ns/1ns
`include "sscc_map.svh"
module sscc_clock_ctrl (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic clkEn,
   input wire logic lsStoppableStrap,
   input wire logic stopMode,
   input wire logic [1:0] subPinRaw,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic hsOscRun,
   output logic lsOscRun,
   output sscc_pkg::sscc_pin_mode_t subPinMode,
   output logic [1:0] portPinIn,
   output logic [2:0] cpuClkSel,
   output logic periMainClk,
   output logic cpuDivOk
);
   sscc_pkg::sscc_state_t s_q, s_d;

   function automatic logic [7:0] sscc_read(input sscc_pkg::sscc_state_t s,
                                            input logic [3:0] a);
      logic [7:0] r;
      r = 8'h00;
      unique case (a)
         `SSCC_OFF_IOM: begin
            r[`SSCC_IOM_STABLE] = s.hsStable;
            r[`SSCC_IOM_HSSTOP] = s.hsStop;
            r[`SSCC_IOM_LSSTOP] = s.lsStop;
         end
         `SSCC_OFF_PCC: begin
            r[`SSCC_PCC_SUBSTART] = s.subStart;
            r[`SSCC_PCC_CLS] = (s.cpuStat == sscc_pkg::SsccCpuSub);
            r[`SSCC_PCC_CSS] = s.cpuSel;
            r[`SSCC_PCC_MCS] = (s.cpuStat == sscc_pkg::SsccCpuMain);
            r[2:0] = s.cpuDiv;
         end
         `SSCC_OFF_OSC: begin
            r[`SSCC_OSC_EXTMAIN] = s.extMain;
            r[`SSCC_OSC_SUBEXT] = s.subExt;
            r[`SSCC_OSC_SUBEN] = s.subEn;
         end
         `SSCC_OFF_MCM: begin
            r[`SSCC_MCM_EXTERNAL_MAIN_SELECT] = s.extSel;
            r[`SSCC_MCM_MODE] = s.mainMode;
         end
         default: r = 8'h00;
      endcase
      return r;
   endfunction

   logic busReq;
   logic wrLo;
   sscc_pkg::sscc_cpu_src_t wantSrc;
   sscc_pkg::sscc_pin_mode_t nextMode;
   assign busReq = wb_cyc_i && wb_stb_i && !s_q.ack;
   assign wrLo = busReq && wb_we_i && wb_sel_i[0];

   always_comb begin
      s_d = s_q;
      // Pin inputs pass two flip-flops before anything reads them
      s_d.subPinSync1 = subPinRaw;
      s_d.subPinSync2 = s_q.subPinSync1;
      // Strap caught once after reset release, never in the reset branch
      if (!s_q.strapTaken) begin
         s_d.lsStoppable = lsStoppableStrap;
         s_d.strapTaken = 1'b1;
      end
      s_d.ack = busReq;
      s_d.rdData = sscc_read(s_q, wb_adr_i);
      if (wrLo) begin
         unique case (wb_adr_i)
            `SSCC_OFF_IOM: begin
               s_d.hsStop = wb_dat_i[`SSCC_IOM_HSSTOP];
               s_d.lsStop = wb_dat_i[`SSCC_IOM_LSSTOP];
            end
            `SSCC_OFF_PCC: begin
               s_d.subStart = wb_dat_i[`SSCC_PCC_SUBSTART];
               s_d.cpuSel = wb_dat_i[`SSCC_PCC_CSS];
               s_d.cpuDiv = wb_dat_i[2:0];
            end
            `SSCC_OFF_OSC: begin
               s_d.extMain = wb_dat_i[`SSCC_OSC_EXTMAIN];
               s_d.subExt = wb_dat_i[`SSCC_OSC_SUBEXT];
               s_d.subEn = wb_dat_i[`SSCC_OSC_SUBEN];
            end
            `SSCC_OFF_MCM: begin
               s_d.extSel = wb_dat_i[`SSCC_MCM_EXTERNAL_MAIN_SELECT];
               s_d.mainMode = wb_dat_i[`SSCC_MCM_MODE];
            end
            default: s_d.hsStop = s_q.hsStop;
         endcase
      end
      // High-speed oscillator; stable flag after a settle count
      s_d.hsRun = !s_q.hsStop && !stopMode;
      if (!s_q.hsRun) begin
         s_d.stableCnt = 4'h0;
         s_d.hsStable = 1'b0;
      end else if (s_q.stableCnt != 4'(`SSCC_STABLE_CYC)) begin
         s_d.stableCnt = s_q.stableCnt + 4'h1;
      end else begin
         s_d.hsStable = 1'b1;
      end
      // Low-speed oscillator runs from reset; stop only if strapped so
      s_d.lsRun = !(s_q.lsStop && s_q.lsStoppable);
      // Subsystem pin mode; STOP mode has no say here
      if (s_q.subStart)
         nextMode = sscc_pkg::SsccXtal;
      else if (s_q.subEn && !s_q.subExt)
         nextMode = sscc_pkg::SsccXtal;
      else if (s_q.subEn && s_q.subExt)
         nextMode = sscc_pkg::SsccExtIn;
      else
         nextMode = sscc_pkg::SsccPort;
      s_d.pinMode = nextMode;
      // Port inputs read zero on pins taken by the oscillator
      s_d.subPinIn[0] = (s_q.pinMode == sscc_pkg::SsccXtal) ? 1'b0 :
                        s_q.subPinSync2[0];
      s_d.subPinIn[1] = (s_q.pinMode == sscc_pkg::SsccPort) ?
                        s_q.subPinSync2[1] : 1'b0;
      // CPU source request; low-speed clock is never a candidate
      if (s_q.cpuSel)
         wantSrc = sscc_pkg::SsccCpuSub;
      else if (s_q.extSel && s_q.mainMode)
         wantSrc = sscc_pkg::SsccCpuMain;
      else
         wantSrc = sscc_pkg::SsccCpuHs;
      // Status moves only after the switch delay elapses
      if (wantSrc == s_q.cpuStat) begin
         s_d.switchCnt = 3'h0;
      end else if (s_q.switchCnt != 3'(`SSCC_SWITCH_CYC - 1)) begin
         s_d.switchCnt = s_q.switchCnt + 3'h1;
      end else begin
         s_d.switchCnt = 3'h0;
         s_d.cpuStat = wantSrc;
      end
      // Subsystem path ignores the divider; only 0..4 are legal codes
      s_d.cpuClkSel = (s_q.cpuStat == sscc_pkg::SsccCpuSub) ? 3'h0 :
                      s_q.cpuDiv;
      s_d.cpuDivOk = (s_q.cpuDiv <= 3'h4);
      s_d.periMain = s_q.extSel;
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         s_q <= '0;
         s_q.cpuDiv <= `SSCC_PCC_RST;
         s_q.lsRun <= 1'b1;
         s_q.hsRun <= 1'b1;
         s_q.cpuStat <= sscc_pkg::SsccCpuHs;
         s_q.pinMode <= sscc_pkg::SsccPort;
         s_q.cpuClkSel <= `SSCC_PCC_RST;
         s_q.cpuDivOk <= 1'b1;
      end else if (clkEn) begin
         s_q <= s_d;
      end
   end

   assign wb_dat_o = {24'h000000, s_q.rdData};
   assign wb_ack_o = s_q.ack;
   assign hsOscRun = s_q.hsRun;
   assign lsOscRun = s_q.lsRun;
   assign subPinMode = s_q.pinMode;
   assign portPinIn = s_q.subPinIn;
   assign cpuClkSel = s_q.cpuClkSel;
   assign periMainClk = s_q.periMain;
   assign cpuDivOk = s_q.cpuDivOk;

   hs_stop_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      clkEn && s_q.hsStop |=> !hsOscRun)
      else $error("hs oscillator ran while stopped");
   sub_status_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      clkEn && s_q.cpuSel && s_q.cpuStat != sscc_pkg::SsccCpuSub &&
      s_q.switchCnt == 3'(`SSCC_SWITCH_CYC - 1) |=> !clkEn ||
      s_q.cpuStat == sscc_pkg::SsccCpuSub)
      else $error("subsystem status not reached");
   port_mode_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      clkEn && !s_q.subEn && !s_q.subStart |=> !clkEn ||
      subPinMode == sscc_pkg::SsccPort)
      else $error("pins not in port mode");
   xtal_mode_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      clkEn && (s_q.subStart || (s_q.subEn && !s_q.subExt)) |=>
      !clkEn || subPinMode == sscc_pkg::SsccXtal)
      else $error("crystal mode not entered");
   ext_mode_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      clkEn && !s_q.subStart && s_q.subEn && s_q.subExt |=>
      !clkEn || subPinMode == sscc_pkg::SsccExtIn)
      else $error("external input mode not entered");
   sub_undiv_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      clkEn && s_q.cpuStat == sscc_pkg::SsccCpuSub |=>
      !clkEn || cpuClkSel == 3'h0)
      else $error("subsystem clock divided");
   ls_option_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      clkEn && !s_q.lsStoppable |=> !clkEn || lsOscRun)
      else $error("unstoppable low-speed clock halted");
   ls_stop_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      clkEn && s_q.lsStop && s_q.lsStoppable |=> !clkEn || !lsOscRun)
      else $error("low-speed clock not halted");
   stop_keep_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      clkEn && stopMode && s_q.subEn && !s_q.subExt |=>
      !clkEn || subPinMode == sscc_pkg::SsccXtal)
      else $error("stop mode halted subsystem clock");
   // Status must hold until the switch counter has run out
   switch_wait_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      s_q.switchCnt != 3'(`SSCC_SWITCH_CYC - 1) |=>
      $stable(s_q.cpuStat))
      else $error("switch timing broken");

   cpu_sub_c: cover property (@(posedge clk_sys) disable iff (!rstn)
      s_q.cpuStat == sscc_pkg::SsccCpuSub);
   ext_in_c: cover property (@(posedge clk_sys) disable iff (!rstn)
      subPinMode == sscc_pkg::SsccExtIn);
   hs_off_c: cover property (@(posedge clk_sys) disable iff (!rstn)
      !hsOscRun);
endmodule

// ==== bench/sscc_clock_ctrl_tb.sv ====
// Self-checking bench of the subsystem and oscillator clock control
`timescale 1ns/1ns
`include "sscc_map.svh"
module sscc_clock_ctrl_tb;
   logic clk_sys, rstn, clkEn, lsStoppableStrap, stopMode;
   logic [1:0] subPinRaw;
   logic wbCyc, wbStb, wbWe;
   logic [3:0] wbAdr, wbSel;
   logic [31:0] wbDatW, wbDatR, rd;
   logic wbAck, hsOscRun, lsOscRun, periMainClk, cpuDivOk;
   sscc_pkg::sscc_pin_mode_t subPinMode;
   logic [1:0] portPinIn;
   logic [2:0] cpuClkSel;
   int fails = 0;
   int tests_run = 0;
   int cycles = 0;
   sscc_clock_ctrl dut_u (.clk_sys(clk_sys), .rstn(rstn), .clkEn(clkEn),
      .lsStoppableStrap(lsStoppableStrap), .stopMode(stopMode),
      .subPinRaw(subPinRaw), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
      .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
      .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck),
      .hsOscRun(hsOscRun), .lsOscRun(lsOscRun), .subPinMode(subPinMode),
      .portPinIn(portPinIn), .cpuClkSel(cpuClkSel),
      .periMainClk(periMainClk), .cpuDivOk(cpuDivOk));
   initial begin
      clk_sys = 0;
      forever #20 clk_sys = ~clk_sys;
   end
   task automatic results();
      $display("Comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Whole run needs well under a thousand cycles
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fails++;
         results();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tk(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // Classic cycle: hold everything until ack is seen at an edge
   task automatic wb(input logic we, input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      wbCyc <= 1; wbStb <= 1; wbWe <= we; wbAdr <= a;
      wbDatW <= {24'h0, d}; wbSel <= 4'hf;
      // Ends once ack is seen at an edge; a missing ack runs into the bench timeout
      do begin
         @(posedge clk_sys);
      end while (wbAck !== 1'b1);
      rd = wbDatR;
      wbCyc <= 0; wbStb <= 0; wbWe <= 0;
   endtask
   task automatic rst(input logic strap);
      rstn <= 0;
      lsStoppableStrap <= strap;
      tk(5);
      rstn <= 1;
      // Pin levels need two sync stages plus the port register
      tk(4);
   endtask
   task automatic t_reset();
      chk(lsOscRun, 1);
      chk(hsOscRun, 1);
      chk(subPinMode, sscc_pkg::SsccPort);
      chk(portPinIn, 2'h2);
      wb(0, `SSCC_OFF_PCC, 8'h0);
      chk(rd, 32'h1);
      wb(0, 4'h2, 8'h0);
      chk(rd, 32'h0);
      $display("Reset test done");
   endtask
   task automatic t_sub();
      subPinRaw <= 2'h3;
      wb(1, `SSCC_OFF_OSC, 8'h10);
      tk(4);
      chk(subPinMode, sscc_pkg::SsccXtal);
      chk(portPinIn, 2'h0);
      // Subsystem crystal keeps running while stopped, high-speed oscillator halts
      stopMode <= 1;
      tk(4);
      chk(subPinMode, sscc_pkg::SsccXtal);
      chk(hsOscRun, 0);
      stopMode <= 0;
      // Selects change only with the subsystem clock off
      wb(1, `SSCC_OFF_OSC, 8'h00);
      tk(4);
      chk(subPinMode, sscc_pkg::SsccPort);
      chk(portPinIn, 2'h3);
      wb(1, `SSCC_OFF_OSC, 8'h30);
      tk(4);
      chk(subPinMode, sscc_pkg::SsccExtIn);
      chk(portPinIn, 2'h1);
      wb(1, `SSCC_OFF_OSC, 8'h20);
      tk(4);
      chk(subPinMode, sscc_pkg::SsccPort);
      chk(portPinIn, 2'h3);
      wb(1, `SSCC_OFF_PCC, 8'h41);
      tk(4);
      chk(subPinMode, sscc_pkg::SsccXtal);
      $display("Subsystem pin test done");
   endtask
   task automatic t_cpu();
      wb(1, `SSCC_OFF_PCC, 8'h53);
      tk(8);
      chk(cpuClkSel, 3'h0);
      wb(0, `SSCC_OFF_PCC, 8'h0);
      chk(rd, 32'h73);
      wb(1, `SSCC_OFF_PCC, 8'h45);
      tk(3);
      chk(cpuDivOk, 0);
      wb(1, `SSCC_OFF_PCC, 8'h44);
      wb(1, `SSCC_OFF_MCM, 8'h05);
      tk(8);
      chk(periMainClk, 1);
      chk(cpuDivOk, 1);
      wb(0, `SSCC_OFF_PCC, 8'h0);
      chk(rd, 32'h4c);
      wb(0, `SSCC_OFF_MCM, 8'h0);
      chk(rd, 32'h05);
      // Subsystem select kept as is while the crystal runs
      wb(1, `SSCC_OFF_OSC, 8'ha0);
      wb(0, `SSCC_OFF_OSC, 8'h0);
      chk(rd, 32'ha0);
      $display("CPU clock test done");
   endtask
   task automatic t_osc(input logic strap);
      // Move the CPU to the main clock and poll before stopping
      wb(1, `SSCC_OFF_MCM, 8'h05);
      tk(8);
      wb(0, `SSCC_OFF_PCC, 8'h0);
      chk(rd[`SSCC_PCC_MCS], 1);
      wb(1, `SSCC_OFF_IOM, 8'h03);
      tk(3);
      chk(hsOscRun, 0);
      chk(lsOscRun, !strap);
      wb(0, `SSCC_OFF_IOM, 8'h0);
      chk(rd, 32'h03);
      wb(1, `SSCC_OFF_IOM, 8'h00);
      tk(20);
      chk(hsOscRun, 1);
      chk(lsOscRun, 1);
      wb(0, `SSCC_OFF_IOM, 8'h0);
      chk(rd, 32'h80);
      // Enable low freezes state, so the stop lands only after
      clkEn <= 0;
      stopMode <= 1;
      tk(4);
      chk(hsOscRun, 1);
      clkEn <= 1;
      tk(3);
      chk(hsOscRun, 0);
      stopMode <= 0;
      tk(2);
      $display("Oscillator stop test done");
   endtask
   initial begin
      clkEn = 1; lsStoppableStrap = 1; stopMode = 0; subPinRaw = 2'h2;
      rstn = 0; wbCyc = 0; wbStb = 0; wbWe = 0; wbAdr = 4'h0;
      wbSel = 4'h0; wbDatW = 32'h0;
      rst(1);
      t_reset();
      t_sub();
      t_cpu();
      t_osc(1);
      rst(0);
      t_osc(0);
      results();
   end
endmodule
